// file: rtl/dcpwm_pkg.sv
// Package: register map, field layout, reset values and timing of the dc-dc PWM block
package dcpwm_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_Q2_CURRENT  = 8'h55;
	localparam logic [7:0] IDX_Q3_CURRENT  = 8'h56;
	localparam logic [7:0] IDX_Q4_CURRENT  = 8'h57;
	localparam logic [7:0] IDX_Q5_CURRENT  = 8'h58;
	localparam logic [7:0] IDX_Q6_CURRENT  = 8'h59;
	localparam logic [7:0] IDX_CONV_PERIOD = 8'h5c;
	localparam logic [7:0] IDX_CONV_SWDLY  = 8'h5d;
	localparam logic [7:0] IDX_CONV_PW     = 8'h5e;
	localparam logic [7:0] IDX_MON_CTRL    = 8'h5f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_PERIOD_FIXED = 6;
	localparam int POS_CAL_START    = 7;
	localparam int POS_FF_POLARITY  = 5;
	localparam int POS_EXT_BATT_EN  = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONV_PERIOD = 8'hff;
	localparam logic [4:0] RST_MIN_OFF     = 5'h14;
	localparam logic [7:0] RST_CONV_PW     = 8'h00;
	localparam logic [7:0] RST_CURRENT     = 8'h00;

	// ----------------------------------------------------------------
	// Timing: one converter tick of 61.035 ns at a 20 ns system clock
	// ----------------------------------------------------------------
	localparam int TICK_PS      = 61035;
	localparam int CLK_PS       = 20000;
	localparam int TICK_CYC     = TICK_PS / CLK_PS;
	localparam int MIN_OFF_ADD  = 4;
	localparam int CAL_TICKS    = 64;

	// ----------------------------------------------------------------
	// Monitor sample from the monitor converter
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [7:0] q2_raw;
		logic [7:0] ext_offset;
		logic [7:0] q3;
		logic [7:0] q4;
		logic [7:0] q5;
		logic [7:0] q6;
	} dcpwm_mon_type;

	typedef enum logic {
		DCPWM_RUN,
		DCPWM_CAL
	} dcpwm_state_type;

endpackage : dcpwm_pkg

// file: rtl/dcpwm_top.sv
// Module: dc-dc converter PWM drive and line transistor current monitor registers
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps

module dcpwm_top
	import dcpwm_pkg::*;
#(
	parameter int         CAL_LEN  = CAL_TICKS,
	parameter logic       FF_SAME  = 1'b0
) (
	input  wire logic          i_sys_clk,
	input  wire logic          i_srst,
	input  wire logic          i_clk_en,
	input  wire logic [9:0]    i_avm_address,
	input  wire logic          i_avm_read,
	input  wire logic          i_avm_write,
	input  wire logic [31:0]   i_avm_writedata,
	input  wire logic [3:0]    i_avm_byteenable,
	output logic      [31:0]   o_avm_readdata,
	output logic               o_avm_waitrequest,
	input  wire dcpwm_mon_type i_mon,
	input  wire logic          i_peak_trip,
	output logic               o_converter_drive_pin,
	output logic               o_feed_forward_pin
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	localparam int DIV_W = $clog2(TICK_CYC + 1);

	// Offset above the raw reading clamps at zero instead of wrapping
	function automatic logic [7:0] sub_sat(input logic [7:0] a, input logic [7:0] b);
		sub_sat = (a > b) ? 8'(a - b) : 8'h00;
	endfunction : sub_sat

	function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
		hit = (addr == {idx, 2'b00});
	endfunction : hit

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic            ack_ff,     nxt_ack;
	logic [7:0]      rdata_ff,   nxt_rdata;
	logic [7:0]      q2_ff,      nxt_q2;
	logic [7:0]      q3_ff,      nxt_q3;
	logic [7:0]      q4_ff,      nxt_q4;
	logic [7:0]      q5_ff,      nxt_q5;
	logic [7:0]      q6_ff,      nxt_q6;
	logic [7:0]      period_ff,  nxt_period;
	logic [4:0]      min_off_ff, nxt_min_off;
	logic            ext_en_ff,  nxt_ext_en;
	logic [7:0]      pw_code_ff, nxt_pw_code;
	logic [2:0]      trip_sync_ff, nxt_trip_sync;
	logic            trip_ff,    nxt_trip;
	logic [DIV_W-1:0] div_ff,    nxt_div;
	logic [7:0]      per_cnt_ff, nxt_per_cnt;
	logic [7:0]      width_ff,   nxt_width;
	logic            drive_ff,   nxt_drive;
	logic            ffpin_ff,   nxt_ffpin;
	logic [15:0]     cal_cnt_ff, nxt_cal_cnt;
	dcpwm_state_type state_ff,   nxt_state;

	logic            wr_fire;
	logic            tick;
	logic [8:0]      off_start;
	logic [7:0]      per_inc;
	logic            wrap;
	logic            cal_req;
	logic [7:0]      swdly_read;

	// ----------------------------------------------------------------
	// Avalon-MM slave: one wait state on every access
	// ----------------------------------------------------------------
	assign o_avm_waitrequest = (i_avm_read | i_avm_write) & ~ack_ff;
	assign o_avm_readdata    = {24'h000000, rdata_ff};
	// Write lands only at the edge where the master sees waitrequest low
	assign wr_fire = i_avm_write & ack_ff & i_avm_byteenable[0];

	// Bit 6 is reserved and reads zero
	assign swdly_read = {(state_ff == DCPWM_CAL), 1'b0, FF_SAME, min_off_ff};

	always_comb begin
		// Ack lasts one cycle, so back-to-back requests each wait once
		nxt_ack   = (i_avm_read | i_avm_write) & ~ack_ff;
		nxt_rdata = rdata_ff;
		if (i_avm_read && !ack_ff) begin
			if (hit(i_avm_address, IDX_Q2_CURRENT)) begin
				nxt_rdata = q2_ff;
			end else if (hit(i_avm_address, IDX_Q3_CURRENT)) begin
				nxt_rdata = q3_ff;
			end else if (hit(i_avm_address, IDX_Q4_CURRENT)) begin
				nxt_rdata = q4_ff;
			end else if (hit(i_avm_address, IDX_Q5_CURRENT)) begin
				nxt_rdata = q5_ff;
			end else if (hit(i_avm_address, IDX_Q6_CURRENT)) begin
				nxt_rdata = q6_ff;
			end else if (hit(i_avm_address, IDX_CONV_PERIOD)) begin
				nxt_rdata = period_ff;
			end else if (hit(i_avm_address, IDX_CONV_SWDLY)) begin
				nxt_rdata = swdly_read;
			end else if (hit(i_avm_address, IDX_CONV_PW)) begin
				nxt_rdata = pw_code_ff;
			end else if (hit(i_avm_address, IDX_MON_CTRL)) begin
				// Own control register: extended battery enable in bit 0
				nxt_rdata = {7'h00, ext_en_ff};
			end else begin
				nxt_rdata = 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	assign cal_req = wr_fire && hit(i_avm_address, IDX_CONV_SWDLY)
		&& i_avm_writedata[POS_CAL_START];

	always_comb begin
		nxt_period  = period_ff;
		nxt_min_off = min_off_ff;
		nxt_ext_en  = ext_en_ff;
		if (wr_fire && hit(i_avm_address, IDX_CONV_PERIOD)) begin
			nxt_period                   = i_avm_writedata[7:0];
			nxt_period[POS_PERIOD_FIXED] = 1'b1;
		end
		if (wr_fire && hit(i_avm_address, IDX_CONV_SWDLY)) begin
			nxt_min_off = i_avm_writedata[4:0];
		end
		if (wr_fire && hit(i_avm_address, IDX_MON_CTRL)) begin
			nxt_ext_en = i_avm_writedata[POS_EXT_BATT_EN];
		end
	end

	// ----------------------------------------------------------------
	// Current monitor codes
	// ----------------------------------------------------------------
	always_comb begin
		nxt_q2 = q2_ff;
		nxt_q3 = q3_ff;
		nxt_q4 = q4_ff;
		nxt_q5 = q5_ff;
		nxt_q6 = q6_ff;
		// Offset removal uses the enable as it stood before this sample
		if (i_mon.valid) begin
			nxt_q2 = ext_en_ff ? sub_sat(i_mon.q2_raw, i_mon.ext_offset) : i_mon.q2_raw;
			nxt_q3 = i_mon.q3;
			nxt_q4 = i_mon.q4;
			nxt_q5 = i_mon.q5;
			nxt_q6 = i_mon.q6;
		end
	end

	// ----------------------------------------------------------------
	// Peak current trip pin synchroniser
	// ----------------------------------------------------------------
	always_comb begin
		nxt_trip_sync = {trip_sync_ff[1:0], i_peak_trip};
		// Level counts only once stages two and three agree, so a glitch cannot cut a pulse
		nxt_trip      = (trip_sync_ff[1] == trip_sync_ff[2]) ? trip_sync_ff[2] : trip_ff;
	end

	// ----------------------------------------------------------------
	// Tick divider and PWM period
	// ----------------------------------------------------------------
	// Tick rounds down to whole clocks, so every timing runs slightly short
	assign tick      = (div_ff == DIV_W'(TICK_CYC - 1));
	assign per_inc   = 8'(per_cnt_ff + 8'h01);
	// A lowered period may leave the counter past its end; wrap at once
	assign wrap      = (per_cnt_ff >= 8'(period_ff - 8'h01));
	assign off_start = {1'b0, period_ff} - 9'({4'h0, min_off_ff} + 9'(MIN_OFF_ADD));

	always_comb begin
		nxt_div     = tick ? '0 : DIV_W'(div_ff + 1'b1);
		nxt_per_cnt = per_cnt_ff;
		nxt_width   = width_ff;
		nxt_drive   = drive_ff;
		nxt_pw_code = pw_code_ff;
		nxt_state   = state_ff;
		nxt_cal_cnt = cal_cnt_ff;
		case (state_ff)
			DCPWM_RUN: begin
				if (cal_req) begin
					nxt_state   = DCPWM_CAL;
					nxt_cal_cnt = '0;
					nxt_drive   = 1'b0;
				end else if (tick) begin
					if (wrap) begin
						nxt_per_cnt = 8'h00;
						nxt_width   = 8'h01;
						// Still high only after a period cut: skip this pulse to keep the off time
						nxt_drive   = (off_start != 9'h000) && !drive_ff;
					end else begin
						nxt_per_cnt = per_inc;
						if (drive_ff) begin
							// Once off, stay off until wrap so the off time holds
							if (({1'b0, per_inc} >= off_start) || trip_ff) begin
								nxt_drive   = 1'b0;
								// Readback adds the off time, so an untripped pulse reads the period
								nxt_pw_code = 8'(width_ff + {3'h0, min_off_ff} + 8'(MIN_OFF_ADD));
							end else begin
								nxt_width = 8'(width_ff + 8'h01);
							end
						end
					end
				end
			end
			DCPWM_CAL: begin
				// Drive held off while the peak monitor is trimmed
				nxt_drive = 1'b0;
				if (tick) begin
					if (cal_cnt_ff >= 16'(CAL_LEN - 1)) begin
						// A fresh start request wins over the finish
						nxt_state = cal_req ? DCPWM_CAL : DCPWM_RUN;
						nxt_cal_cnt = '0;
						nxt_per_cnt = 8'h00;
					end else begin
						nxt_cal_cnt = 16'(cal_cnt_ff + 16'h0001);
					end
				end
			end
			default: begin
				nxt_state = DCPWM_RUN;
				nxt_drive = 1'b0;
			end
		endcase
		// Taken from the next drive value so both pins switch on the same edge
		nxt_ffpin = FF_SAME ? nxt_drive : ~nxt_drive;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Clock enable low freezes every flop, bus handshake included
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ack_ff       <= 1'b0;
			rdata_ff     <= 8'h00;
			q2_ff        <= RST_CURRENT;
			q3_ff        <= RST_CURRENT;
			q4_ff        <= RST_CURRENT;
			q5_ff        <= RST_CURRENT;
			q6_ff        <= RST_CURRENT;
			period_ff    <= RST_CONV_PERIOD;
			min_off_ff   <= RST_MIN_OFF;
			ext_en_ff    <= 1'b0;
			pw_code_ff   <= RST_CONV_PW;
			trip_sync_ff <= 3'h0;
			trip_ff      <= 1'b0;
			div_ff       <= '0;
			per_cnt_ff   <= 8'h00;
			width_ff     <= 8'h00;
			drive_ff     <= 1'b0;
			ffpin_ff     <= ~FF_SAME;
			cal_cnt_ff   <= 16'h0000;
			state_ff     <= DCPWM_RUN;
		end else if (i_clk_en) begin
			ack_ff       <= nxt_ack;
			rdata_ff     <= nxt_rdata;
			q2_ff        <= nxt_q2;
			q3_ff        <= nxt_q3;
			q4_ff        <= nxt_q4;
			q5_ff        <= nxt_q5;
			q6_ff        <= nxt_q6;
			period_ff    <= nxt_period;
			min_off_ff   <= nxt_min_off;
			ext_en_ff    <= nxt_ext_en;
			pw_code_ff   <= nxt_pw_code;
			trip_sync_ff <= nxt_trip_sync;
			trip_ff      <= nxt_trip;
			div_ff       <= nxt_div;
			per_cnt_ff   <= nxt_per_cnt;
			width_ff     <= nxt_width;
			drive_ff     <= nxt_drive;
			ffpin_ff     <= nxt_ffpin;
			cal_cnt_ff   <= nxt_cal_cnt;
			state_ff     <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	assign o_converter_drive_pin = drive_ff;
	assign o_feed_forward_pin    = ffpin_ff;

endmodule : dcpwm_top

// file: testbench/dcpwm_assertions.sv
// Port-level checks for the dc-dc PWM block
`timescale 1ns/10ps
module dcpwm_assertions
	import dcpwm_pkg::*;
#(
	parameter int   CAL_LEN = CAL_TICKS,
	parameter logic FF_SAME = 1'b0
) (
	input wire logic        i_sys_clk,
	input wire logic        i_srst,
	input wire logic [9:0]  i_avm_address,
	input wire logic        i_avm_read,
	input wire logic        i_avm_write,
	input wire logic [31:0] i_avm_writedata,
	input wire logic [3:0]  i_avm_byteenable,
	input wire logic [31:0] o_avm_readdata,
	input wire logic        o_avm_waitrequest,
	input wire logic        i_peak_trip,
	input wire logic        o_converter_drive_pin,
	input wire logic        o_feed_forward_pin
);
	localparam int CAL_CYC = CAL_LEN * TICK_CYC;
	logic        ack;
	logic [7:0]  per_ff;
	logic [4:0]  tof_ff;
	logic        wr_ff;
	logic [11:0] on_ff;
	logic [11:0] off_ff;
	logic [11:0] cal_ff;
	// Shadow timing codes; a write mid-phase may legally bend that phase
	assign ack = i_avm_write && !o_avm_waitrequest && i_avm_byteenable[0];
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			per_ff <= 8'hff;
			tof_ff <= 5'h14;
			wr_ff  <= 1'b1;
			on_ff  <= 12'h0;
			off_ff <= 12'h0;
			cal_ff <= 12'h0;
		end else begin
			if (ack && i_avm_address == 10'h170) per_ff <= i_avm_writedata[7:0] | 8'h40;
			if (ack && i_avm_address == 10'h174) tof_ff <= i_avm_writedata[4:0];
			cal_ff <= (ack && i_avm_address == 10'h174 && i_avm_writedata[7]) ? 12'(CAL_CYC)
				: cal_ff - {11'h0, cal_ff != 12'h0};
			wr_ff  <= ack || (wr_ff && !$changed(o_converter_drive_pin));
			on_ff  <= o_converter_drive_pin ? on_ff + 12'h1 : 12'h0;
			off_ff <= o_converter_drive_pin ? 12'h0 : off_ff + 12'h1;
		end
	end
	default clocking dcb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);
	a_wait_one: assert property ((i_avm_read || i_avm_write) && o_avm_waitrequest |=> !o_avm_waitrequest)
		else $error("waitrequest longer than one cycle");
	a_idle_ready: assert property (!i_avm_read && !i_avm_write |-> !o_avm_waitrequest)
		else $error("waitrequest without request");
	a_rdata_byte: assert property (i_avm_read && !o_avm_waitrequest |-> o_avm_readdata[31:8] == 24'h0)
		else $error("readdata upper bits set");
	a_ff_follow: assert property (o_feed_forward_pin == (FF_SAME ? o_converter_drive_pin : !o_converter_drive_pin))
		else $error("feed-forward polarity wrong");
	a_off_min: assert property ($rose(o_converter_drive_pin) |->
		wr_ff || off_ff >= (12'(tof_ff) + 12'd4) * 12'(TICK_CYC)) else $error("off time too short");
	a_on_max: assert property ($fell(o_converter_drive_pin) |->
		wr_ff || on_ff <= (12'(per_ff) - 12'(tof_ff) - 12'd4) * 12'(TICK_CYC)) else $error("pulse too long");
	a_cal_quiet: assert property (cal_ff != 12'h0 && cal_ff < 12'(CAL_CYC - 2) |-> !o_converter_drive_pin)
		else $error("drive during calibration");
	a_trip_cut: assert property (i_peak_trip [*6] |-> ##[0:6] !o_converter_drive_pin)
		else $error("peak trip ignored");
	c_pulse: cover property ($fell(o_converter_drive_pin) && !wr_ff);
	c_cal: cover property (cal_ff == 12'h1);
	c_trip: cover property (i_peak_trip && o_converter_drive_pin);
endmodule : dcpwm_assertions

// file: testbench/dcpwm_partner.sv
// Switching transistor model: peak current reached a set time into each pulse
`timescale 1ns/10ps
module dcpwm_partner (
	input  wire logic       i_sys_clk,
	input  wire logic       i_drive,
	input  wire logic [7:0] i_trip_after,
	output logic            o_peak_trip
);
	logic [7:0] ramp_ff;
	logic [7:0] nxt_ramp;
	// Inductor current ramps only while the switch conducts
	always_comb nxt_ramp = i_drive ? ramp_ff + {7'h0, ramp_ff != 8'hff} : 8'h00;
	always_ff @(posedge i_sys_clk) ramp_ff <= nxt_ramp;
	// Zero means a slow converter that never reaches the peak
	assign o_peak_trip = i_trip_after != 8'h00 && ramp_ff >= i_trip_after;
endmodule : dcpwm_partner

// file: testbench/test_dcpwm_top.sv
// Self-checking bench for the dc-dc PWM and current monitor block
`timescale 1ns/10ps
module test_dcpwm_top import dcpwm_pkg::*;;
	logic          i_sys_clk = 1'b0;
	logic          i_srst = 1'b1;
	logic          i_clk_en = 1'b1;
	logic [9:0]    i_avm_address = 10'h000;
	logic          i_avm_read = 1'b0;
	logic          i_avm_write = 1'b0;
	logic [31:0]   i_avm_writedata = 32'h0;
	logic [3:0]    i_avm_byteenable = 4'h0;
	logic [31:0]   o_avm_readdata;
	logic          o_avm_waitrequest;
	dcpwm_mon_type i_mon = '0;
	logic          i_peak_trip;
	logic          o_converter_drive_pin;
	logic          o_feed_forward_pin;
	logic [7:0]    trip_after = 8'h00;
	logic [31:0]   q;
	int            bad_count = 0;
	int            n_compared = 0;
	logic [9:0]    ra [9] = '{10'h154, 10'h158, 10'h15c, 10'h160, 10'h164, 10'h170, 10'h174, 10'h178, 10'h17c};
	logic [7:0]    rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h14, 8'h00, 8'h00};
	always #10 i_sys_clk = ~i_sys_clk;
	dcpwm_top #(.CAL_LEN(4), .FF_SAME(1'b0)) dcpwm_top_inst (.i_sys_clk, .i_srst, .i_clk_en, .i_avm_address,
		.i_avm_read, .i_avm_write, .i_avm_writedata, .i_avm_byteenable, .o_avm_readdata, .o_avm_waitrequest,
		.i_mon, .i_peak_trip, .o_converter_drive_pin, .o_feed_forward_pin);
	dcpwm_partner dcpwm_partner_inst (.i_sys_clk, .i_drive(o_converter_drive_pin), .i_trip_after(trip_after),
		.o_peak_trip(i_peak_trip));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d, input logic [3:0] be,
		output logic [31:0] r);
		int n;
		n = 0;
		i_avm_address    <= a;
		i_avm_write      <= w;
		i_avm_read       <= ~w;
		i_avm_writedata  <= {24'h0, d};
		i_avm_byteenable <= be;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (o_avm_waitrequest !== 1'b0 && n < 100);
		if (o_avm_waitrequest !== 1'b0) begin
			$display("ERROR waitrequest expected 0 seen %b", o_avm_waitrequest);
			bad_count++;
		end
		r = o_avm_readdata;
		i_avm_read  <= 1'b0;
		i_avm_write <= 1'b0;
		@(posedge i_sys_clk);
	endtask : bus
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 8'h00, 4'hf, r);
		chk($sformatf("reg %h", a), {24'h0, e}, r);
	endtask : rd
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(a, 1'b1, d, 4'h1, q);
	endtask : wr
	task automatic mon(input logic [7:0] a, b, c, d, e, f);
		i_mon <= {1'b1, a, b, c, d, e, f};
		@(posedge i_sys_clk);
		i_mon.valid <= 1'b0;
		@(posedge i_sys_clk);
	endtask : mon
	task automatic wt(input logic v, output int n);
		n = 0;
		while (o_converter_drive_pin !== v && n < 2000) begin
			@(posedge i_sys_clk);
			n++;
		end
		if (o_converter_drive_pin !== v) begin
			$display("ERROR drive pin expected %b seen %b", v, o_converter_drive_pin);
			bad_count++;
		end
	endtask : wt
	task automatic skip;
		int n;
		repeat (2) begin
			wt(1'b0, n);
			wt(1'b1, n);
		end
	endtask : skip
	task automatic t_reset;
		for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
	endtask : t_reset
	task automatic t_access;
		wr(10'h170, 8'h00);
		rd(10'h170, 8'h40);
		wr(10'h170, 8'hbf);
		rd(10'h170, 8'hff);
		bus(10'h170, 1'b1, 8'h40, 4'he, q);
		rd(10'h170, 8'hff);
		wr(10'h154, 8'hff);
		rd(10'h154, 8'h00);
		wr(10'h174, 8'h3f);
		rd(10'h174, 8'h1f);
		wr(10'h150, 8'hff);
		rd(10'h150, 8'h00);
	endtask : t_access
	task automatic t_mon;
		mon(8'h80, 8'h30, 8'h01, 8'hff, 8'h7f, 8'hfe);
		rd(10'h154, 8'h80);
		rd(10'h158, 8'h01);
		rd(10'h15c, 8'hff);
		rd(10'h160, 8'h7f);
		rd(10'h164, 8'hfe);
		wr(10'h17c, 8'h01);
		mon(8'h80, 8'h30, 8'h02, 8'h00, 8'h00, 8'h00);
		rd(10'h154, 8'h50);
		rd(10'h158, 8'h02);
		mon(8'h20, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00);
		rd(10'h154, 8'h00);
	endtask : t_mon
	task automatic t_pwm;
		logic [7:0] p [2] = '{8'h40, 8'hc0};
		logic [4:0] t [2] = '{5'h00, 5'h1f};
		int hi, lo;
		for (int i = 0; i < 2; i++) begin
			wr(10'h170, p[i]);
			wr(10'h174, {3'h0, t[i]});
			skip();
			wt(1'b0, hi);
			wt(1'b1, lo);
			chk("high cycles", (p[i] - t[i] - 4) * TICK_CYC, hi);
			chk("low cycles", (t[i] + 4) * TICK_CYC, lo);
			rd(10'h178, p[i]);
		end
	endtask : t_pwm
	task automatic t_trip;
		int hi;
		wr(10'h170, 8'h40);
		wr(10'h174, 8'h02);
		trip_after <= 8'd40;
		skip();
		wt(1'b0, hi);
		chk("cut pulse", 1, hi < 174);
		rd(10'h178, 8'(hi / TICK_CYC + 6));
		chk("ff pin", {31'h0, !o_converter_drive_pin}, {31'h0, o_feed_forward_pin});
		trip_after <= 8'h00;
	endtask : t_trip
	task automatic t_freeze;
		int n;
		skip();
		wt(1'b0, n);
		i_clk_en <= 1'b0;
		repeat (100) @(posedge i_sys_clk);
		chk("frozen drive", 32'h0, {31'h0, o_converter_drive_pin});
		i_clk_en <= 1'b1;
		wt(1'b1, n);
		chk("frozen off cycles", (2 + MIN_OFF_ADD) * TICK_CYC, n);
	endtask : t_freeze
	task automatic t_cal;
		wr(10'h174, 8'h85);
		rd(10'h174, 8'h85);
		repeat (30) @(posedge i_sys_clk);
		rd(10'h174, 8'h05);
	endtask : t_cal
	task automatic print_verdict;
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		@(posedge i_sys_clk);
		t_reset();
		t_access();
		t_mon();
		t_pwm();
		t_trip();
		t_freeze();
		t_cal();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		bad_count++;
		print_verdict();
	end
endmodule : test_dcpwm_top
bind dcpwm_top dcpwm_assertions #(.CAL_LEN(CAL_LEN), .FF_SAME(FF_SAME)) dcpwm_assertions_inst (.i_sys_clk, .i_srst,
	.i_avm_address, .i_avm_read, .i_avm_write, .i_avm_writedata, .i_avm_byteenable, .o_avm_readdata,
	.o_avm_waitrequest, .i_peak_trip, .o_converter_drive_pin, .o_feed_forward_pin);
